//--- sim/fpds_motor_model.sv
/* Motor driver stand-in: counts the drive pulses of the latest move.
   Assumes one-cycle pulses and a busy level on the same clock. */
`timescale 1ns/10ps
module fpds_motor_model
(
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // Drive pins.
  input  wire logic        pulse_i,
  input  wire logic        busy_i,
  // Pulses of the latest move.
  output logic      [31:0] count_o
);
  logic busy_q; // Busy one cycle ago.
  // Restart at each move start, since the bench compares per move.
  always_ff @(posedge clock_i)
  begin
    busy_q <= busy_i;
    if (rst_i)
      count_o <= 32'h0;
    else if (busy_i && !busy_q)
      count_o <= {31'h0, pulse_i};
    else if (pulse_i)
      count_o <= count_o + 32'h1;
  end
endmodule : fpds_motor_model

//--- sim/fpds_top_tb.sv
/* Self-checking bench of the sequencer: bus tasks, moves, scoreboard.
   Assumes the one-cycle Avalon answer stated for the top module. */
`timescale 1ns/10ps
module fpds_top_tb;
  logic        clock_i = 0, rst_i = 1, read_i = 0, write_i = 0;
  logic [5:0]  address_i = 6'h00;
  logic [31:0] writedata_i = 32'h0, readdata_o, count;
  logic        waitrequest_o, pulse_o, dir_o, busy_o, busy_q, dir_cap;
  logic [31:0] rd_q[$];  // Expected read data, oldest first.
  logic [32:0] mv_q[$];  // Expected {direction, pulse count} per move.
  logic [1:0]  fall_q = 2'b00; // Busy fell one and two cycles ago.
  int          mismatches = 0, n_checks = 0, pos = 0, r;

  always #2 clock_i = ~clock_i;

  fpds_top #(.RAMP_DIV(16'h0004)) u_dut (.clock_i(clock_i), .rst_i(rst_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .byteenable_i(4'hf), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .pulse_o(pulse_o), .dir_o(dir_o), .busy_o(busy_o));
  fpds_motor_model u_motor (.clock_i(clock_i), .rst_i(rst_i),
    .pulse_i(pulse_o), .busy_i(busy_o), .count_o(count));

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task cmp_read(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_read

  task cmp_move(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_move

  // Request held until waitrequest is seen low, then released.
  task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clock_i);
    address_i   <= a;
    writedata_i <= d;
    write_i     <= 1'b1;
    do @(posedge clock_i); while (waitrequest_o !== 1'b0);
    write_i <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [5:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    @(posedge clock_i);
    address_i <= a;
    read_i    <= 1'b1;
    do @(posedge clock_i); while (waitrequest_o !== 1'b0);
    read_i <= 1'b0;
  endtask : bus_rd

  // Runs one move; ovr rewrites the count after k pulses when nonzero.
  task automatic move(input logic [7:0] cmd, input int tp, ovr, k);
    int   mag, cnt;
    logic dir;
    mag = (cmd == 8'h54) ? tp - pos : tp;
    dir = (cmd == 8'h51) ? (mag < 0) : (mag >= 0);
    cnt = (mag < 0) ? -mag : mag;
    if (ovr != 0)
      cnt = (ovr > k) ? ovr : k;
    mv_q.push_back({dir, cnt[31:0]});
    pos += dir ? cnt : -cnt;
    bus_wr(6'h04, tp);
    bus_wr(6'h00, {24'h0, cmd});
    wait (busy_o === 1'b1);
    if (ovr != 0)
    begin
      repeat (k) @(posedge pulse_o);
      bus_wr(6'h04, ovr);
    end
    wait (busy_o === 1'b0);
    bus_rd(6'h24, pos);
    $display("test done: command %h pulses %0d", cmd, cnt);
  endtask : move

  // Scoreboard: read data when answered; the pulse total two cycles
  // after busy falls, once the last pulse has reached the motor model.
  // It never waits, so no read answer can slip past it.
  always @(posedge clock_i)
  begin
    if (read_i === 1'b1 && waitrequest_o === 1'b0)
      cmp_read(readdata_o, rd_q.pop_front());
    if (fall_q[1])
      cmp_move({dir_cap, count}, mv_q.pop_front());
    if (busy_o === 1'b1)
      dir_cap <= dir_o;
    fall_q <= {fall_q[0], busy_q === 1'b1 && busy_o === 1'b0};
    busy_q <= busy_o;
  end

  initial
  begin
    #400000;
    mismatches++;
    report_and_stop;
  end

  initial
  begin
    r = $urandom(95);
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    bus_rd(6'h1c, 32'h0);
    bus_rd(6'h3c, 32'h0);
    bus_wr(6'h10, 32'h8000);
    bus_wr(6'h14, 32'hffff);
    bus_wr(6'h08, 32'h0100);
    r = 4 + $urandom % 12;
    move(8'h50, r, 0, 0);
    move(8'h50, -r, 0, 0);
    move(8'h51, -r, 0, 0);
    move(8'h51, r, 0, 0);
    move(8'h54, pos - 5 - r, 0, 0);
    move(8'h54, 9, 0, 0);
    bus_wr(6'h1c, 32'h3);
    bus_rd(6'h1c, 32'h3);
    move(8'h50, 12, 20, 8);
    move(8'h50, 30, 1, 3);
    bus_wr(6'h20, 32'h1);
    bus_wr(6'h18, 32'h5);
    bus_wr(6'h00, 32'h07);
    bus_rd(6'h18, 32'h5);
    move(8'h51, -10, 0, 0);
    repeat (4) @(posedge clock_i);
    report_and_stop;
  end
endmodule : fpds_top_tb

//--- verilog/fpds_drv_if.sv
/*
  Carrier between the sequencer, the speed ramp and the pulse generator.
  Assumes all three parties share one clock.
*/
`timescale 1ns/10ps
interface fpds_drv_if;
  import fpds_pkg::*;
  logic         run;        // Move in progress.
  logic         decel;      // Ramp down toward the initial speed.
  logic         at_top;     // Speed has reached the drive speed.
  logic         step;       // One drive pulse is due this cycle.
  fpds_speed_t  speed;      // Present speed.
  fpds_speed_t  accel;      // Acceleration step.
  fpds_speed_t  decel_rate; // Deceleration step, zero means use accel.
  fpds_speed_t  init_speed; // Starting and finishing speed.
  fpds_speed_t  drive;      // Cruise speed.

  modport seq  (output run, decel, accel, decel_rate, init_speed, drive,
                input  speed, at_top, step);
  modport ramp (input  run, decel, accel, decel_rate, init_speed, drive,
                output speed, at_top);
  modport pgen (input  run, speed,
                output step);
endinterface : fpds_drv_if

//--- verilog/fpds_map.svh
/*
  Register offsets, field positions, reset values, command codes and
  timing counts of the fixed pulse drive sequencer.
  Assumes a 32-bit Avalon-MM slave with byte addresses.
*/
`ifndef FPDS_MAP_SVH
`define FPDS_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define FPDS_OFF_COMMAND      6'h00
`define FPDS_OFF_TARGET       6'h04
`define FPDS_OFF_ACCEL        6'h08
`define FPDS_OFF_DECEL        6'h0c
`define FPDS_OFF_INIT_SPEED   6'h10
`define FPDS_OFF_DRIVE_SPEED  6'h14
`define FPDS_OFF_DECEL_POINT  6'h18
`define FPDS_OFF_DECEL_OFFSET 6'h1c
`define FPDS_OFF_MODE_THREE   6'h20
`define FPDS_OFF_LOGICAL_POS  6'h24
`define FPDS_OFF_STATUS       6'h28

// ----------------------------------------------------------------------
// Command codes, field positions and reset values
// ----------------------------------------------------------------------
`define FPDS_CMD_RELATIVE     8'h50
`define FPDS_CMD_COUNTER_REL  8'h51
`define FPDS_CMD_ABSOLUTE     8'h54
`define FPDS_CMD_LOAD_DPOINT  8'h07
`define FPDS_MANUAL_DECEL_BIT 0
`define FPDS_STAT_BUSY_BIT    0
`define FPDS_STAT_DECEL_BIT   1
`define FPDS_STAT_TOP_BIT     2
`define FPDS_STAT_DIR_BIT     3
`define FPDS_OFFSET_RESET     32'h0000_0000
`define FPDS_INIT_SPEED_RESET 16'h0010
`define FPDS_DRIVE_RESET      16'h0100
`define FPDS_ACCEL_RESET      16'h0001

// ----------------------------------------------------------------------
// Timing: clock cycles between two speed ramp steps
// ----------------------------------------------------------------------
`define FPDS_RAMP_DIV         16'h00fa

`endif

//--- verilog/fpds_pgen.sv
/*
  Phase accumulator that turns a speed into one-cycle step requests.
  Assumes speed is stable between ramp ticks.
*/
`timescale 1ns/10ps
module fpds_pgen
  import fpds_pkg::*;
#(
  parameter int ACC_W = 24
)
(
  // Clock and reset.
  input  wire logic  clock_i,
  input  wire logic  rst_i,
  // Sequencer side.
  fpds_drv_if.pgen   drv
);

  logic [ACC_W-1:0] acc_q; // Fractional pulse phase.
  logic [ACC_W:0]   sum;   // Phase plus speed, with carry.

  assign sum = {1'b0, acc_q} + {{(ACC_W-15){1'b0}}, drv.speed};

  // A carry out of the accumulator is one pulse due.
  always_ff @(posedge clock_i)
  begin
    if (rst_i || !drv.run)
    begin
      acc_q    <= '0;
      drv.step <= 1'b0;
    end
    else
    begin
      acc_q    <= sum[ACC_W-1:0];
      drv.step <= sum[ACC_W];
    end
  end

endmodule : fpds_pgen

//--- verilog/fpds_pkg.sv
/*
  Types shared by the fixed pulse drive sequencer modules.
  Assumes fpds_map.svh supplies the numeric constants.
*/
package fpds_pkg;

  // Speed value in phase accumulator increments per clock.
  typedef logic [15:0] fpds_speed_t;

  // Kind of fixed pulse move in progress.
  typedef enum logic [1:0]
  {
    FPDS_MOVE_RELATIVE,
    FPDS_MOVE_COUNTER,
    FPDS_MOVE_ABSOLUTE
  } fpds_move_t;

  // Sequencer state.
  typedef enum logic
  {
    FPDS_IDLE,
    FPDS_RUN
  } fpds_state_t;

endpackage : fpds_pkg

//--- verilog/fpds_ramp.sv
/*
  Linear speed ramp: climbs from the initial speed to the drive speed and
  falls back when asked to decelerate.
  Assumes run and decel come from the sequencer on the same clock.
*/
`timescale 1ns/10ps
`include "fpds_map.svh"
module fpds_ramp
  import fpds_pkg::*;
#(
  parameter logic [15:0] RAMP_DIV = `FPDS_RAMP_DIV
)
(
  // Clock and reset.
  input  wire logic  clock_i,
  input  wire logic  rst_i,
  // Sequencer side.
  fpds_drv_if.ramp   drv
);

  logic [15:0] div_q; // Ramp step divider.
  logic        tick;  // One-cycle ramp enable.
  fpds_speed_t dstep; // Effective deceleration step.

  assign tick  = (div_q == 16'h0000);
  assign dstep = (drv.decel_rate != 16'h0000) ? drv.decel_rate : drv.accel;
  assign drv.at_top = (drv.speed >= drv.drive);

  // Divider that paces the speed changes.
  always_ff @(posedge clock_i)
  begin
    if (rst_i || !drv.run || tick)
      div_q <= RAMP_DIV - 16'h0001;
    else
      div_q <= div_q - 16'h0001;
  end

  // Speed register; saturates at either end so it never wraps.
  always_ff @(posedge clock_i)
  begin
    if (rst_i || !drv.run)
      drv.speed <= drv.init_speed;
    else if (tick && drv.decel)
    begin
      // Going down, stopping at the initial speed.
      // Compared one bit wider so a high initial speed cannot wrap.
      if ({1'b0, drv.speed} > {1'b0, drv.init_speed} + {1'b0, dstep})
        drv.speed <= drv.speed - dstep;
      else
        drv.speed <= drv.init_speed;
    end
    else if (tick && !drv.at_top)
    begin
      // Going up, which also covers a re-acceleration after decel.
      // The carry is kept, so a step past the top saturates instead of
      // wrapping to a near-zero speed.
      if ({1'b0, drv.speed} + {1'b0, drv.accel} < {1'b0, drv.drive})
        drv.speed <= drv.speed + drv.accel;
      else
        drv.speed <= drv.drive;
    end
  end

endmodule : fpds_ramp

//--- verilog/fpds_top.sv
/*
  Fixed pulse drive sequencer for one axis: relative, absolute and
  counter-relative moves with automatic or manual deceleration.
  Assumes an Avalon-MM master on the same clock and a motor driver that
  takes a one-cycle pulse with a level direction.
*/
// Added by the designer: the address map and register access over Avalon-MM.
// Overview of operation
// - Relative move: sign of count gives direction
// - Command 50h starts relative move
// - Auto decel when remaining below accel pulses
// - Absolute: target minus logical position
// - Command 54h starts absolute move
// - Counter-relative drives opposite to count sign
// - Command 51h starts counter-relative move
// - New count accepted during relative moves
// - Raised count during decel re-accelerates
// - Count below output pulses stops immediately
// - Mode bit plus 07h selects manual point
// - Decel pulses equal acceleration pulses
// - Signed offset shifts auto decel earlier
// - Decel offset resets to zero
`timescale 1ns/10ps
`include "fpds_map.svh"
module fpds_top
  import fpds_pkg::*;
#(
  parameter logic [15:0] RAMP_DIV = `FPDS_RAMP_DIV
)
(
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // Avalon-MM slave.
  input  wire logic [5:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [3:0]  byteenable_i,
  input  wire logic [31:0] writedata_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  // Motor driver.
  output logic             pulse_o,
  output logic             dir_o,
  output logic             busy_o
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  fpds_drv_if drv ();                  // Link to ramp and pulse generator.

  fpds_state_t        state_q;         // Idle or moving.
  fpds_move_t         move_q;          // Kind of move in progress.
  logic               waitreq_q;       // Bus wait, low for one answer.
  logic [31:0]        rdata_q;         // Registered read data.
  logic               pulse_q;         // Drive pulse to the motor.
  logic               dir_q;           // One means positive direction.
  logic signed [31:0] target_q;        // Target count or coordinate.
  logic signed [31:0] logpos_q;        // Logical position counter.
  logic signed [31:0] offset_q;        // Deceleration offset.
  logic [31:0]        total_q;         // Pulses to output this move.
  logic [31:0]        out_cnt_q;       // Pulses output so far.
  logic [31:0]        acc_cnt_q;       // Pulses output while accelerating.
  logic [31:0]        dpoint_stage_q;  // Manual point before 07h.
  logic [31:0]        dpoint_q;        // Active manual decel point.
  logic               manual_q;        // Manual deceleration mode.
  fpds_speed_t        accel_q;         // Acceleration step.
  fpds_speed_t        decel_q;         // Deceleration step.
  fpds_speed_t        init_q;          // Initial speed.
  fpds_speed_t        drive_q;         // Drive speed.

  logic               req;             // Bus request pending.
  logic               wr_go;           // Write takes effect now.
  logic [31:0]        wmerge;          // Write data as received from the bus.
  logic               cmd_wr;          // Command register written.
  logic               tgt_wr;          // Target register written.
  logic [31:0]        remaining;       // Pulses still to output.
  logic signed [33:0] auto_point;      // Accel pulses plus offset.
  logic               decel_now;       // Deceleration wanted.
  logic signed [31:0] abs_diff;        // Absolute target minus position.
  logic               start;           // A move starts this cycle.
  logic [31:0]        start_total;     // Pulse count of that move.
  logic               start_dir;       // Direction of that move.
  fpds_move_t         start_move;      // Kind of that move.
  logic [31:0]        new_total;       // Magnitude of a rewritten target.

  // --------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------
  // Magnitude of a signed count; the sign bit is the direction.
  function automatic logic [31:0] fpds_mag(input logic signed [31:0] v);
    fpds_mag = v[31] ? (32'h0000_0000 - v) : v;
  endfunction : fpds_mag

  // Merges write data into an old value lane by lane.
  function automatic logic [31:0] fpds_lanes(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
    fpds_lanes = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        fpds_lanes[i*8 +: 8] = nw[i*8 +: 8];
  endfunction : fpds_lanes

  // --------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------
  assign req    = read_i || write_i;
  assign wr_go  = write_i && !waitreq_q;
  assign wmerge = writedata_i;
  assign cmd_wr = wr_go && (address_i == `FPDS_OFF_COMMAND)
                  && byteenable_i[0];
  assign tgt_wr = wr_go && (address_i == `FPDS_OFF_TARGET);

  // Wait is dropped for one cycle after each cycle with a request and wait high, so every
  // access completes in exactly two cycles.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      waitreq_q <= 1'b1;
    else
      waitreq_q <= !(req && waitreq_q);
  end

  // Read data is captured together with the wait release.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      rdata_q <= 32'h0000_0000;
    else if (read_i && waitreq_q)
    begin
      unique case (address_i)
        `FPDS_OFF_TARGET:       rdata_q <= target_q;
        `FPDS_OFF_ACCEL:        rdata_q <= {16'h0000, accel_q};
        `FPDS_OFF_DECEL:        rdata_q <= {16'h0000, decel_q};
        `FPDS_OFF_INIT_SPEED:   rdata_q <= {16'h0000, init_q};
        `FPDS_OFF_DRIVE_SPEED:  rdata_q <= {16'h0000, drive_q};
        `FPDS_OFF_DECEL_POINT:  rdata_q <= dpoint_q;
        `FPDS_OFF_DECEL_OFFSET: rdata_q <= offset_q;
        `FPDS_OFF_MODE_THREE:   rdata_q <= {31'h0, manual_q};
        `FPDS_OFF_LOGICAL_POS:  rdata_q <= logpos_q;
        `FPDS_OFF_STATUS:
          rdata_q <= {28'h0, dir_q, drv.at_top, decel_now,
                      state_q == FPDS_RUN};
        // Command is write only; unmapped addresses read zero.
        default:                rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Parameter registers, byte lanes honoured.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      target_q       <= 32'h0000_0000;
      accel_q        <= `FPDS_ACCEL_RESET;
      decel_q        <= 16'h0000;
      init_q         <= `FPDS_INIT_SPEED_RESET;
      drive_q        <= `FPDS_DRIVE_RESET;
      dpoint_stage_q <= 32'h0000_0000;
      offset_q       <= `FPDS_OFFSET_RESET;
      manual_q       <= 1'b0;
    end
    else if (wr_go)
    begin
      unique case (address_i)
        // Held signed so its top bit is the direction.
        `FPDS_OFF_TARGET:
          target_q <= fpds_lanes(target_q, wmerge, byteenable_i);
        `FPDS_OFF_ACCEL:
          accel_q <= 16'(fpds_lanes({16'h0, accel_q}, wmerge,
                                    byteenable_i));
        `FPDS_OFF_DECEL:
          decel_q <= 16'(fpds_lanes({16'h0, decel_q}, wmerge,
                                    byteenable_i));
        `FPDS_OFF_INIT_SPEED:
          init_q <= 16'(fpds_lanes({16'h0, init_q}, wmerge,
                                   byteenable_i));
        `FPDS_OFF_DRIVE_SPEED:
          drive_q <= 16'(fpds_lanes({16'h0, drive_q}, wmerge,
                                    byteenable_i));
        `FPDS_OFF_DECEL_POINT:
          dpoint_stage_q <= fpds_lanes(dpoint_stage_q, wmerge,
                                       byteenable_i);
        `FPDS_OFF_DECEL_OFFSET:
          offset_q <= fpds_lanes(offset_q, wmerge, byteenable_i);
        `FPDS_OFF_MODE_THREE:
          if (byteenable_i[0])
            manual_q <= wmerge[`FPDS_MANUAL_DECEL_BIT];
        default:
          manual_q <= manual_q;
      endcase
    end
  end

  // The manual point only becomes active through its load command.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      dpoint_q <= 32'h0000_0000;
    else if (cmd_wr && wmerge[7:0] == `FPDS_CMD_LOAD_DPOINT)
      dpoint_q <= dpoint_stage_q;
  end

  // --------------------------------------------------------------------
  // Command decode and move planning
  // --------------------------------------------------------------------
  assign abs_diff = target_q - logpos_q;

  // Works out direction and count of a freshly commanded move.
  always_comb
  begin
    start       = 1'b0;
    start_total = fpds_mag(target_q);
    start_dir   = !target_q[31];
    start_move  = FPDS_MOVE_RELATIVE;
    if (cmd_wr && state_q == FPDS_IDLE)
    begin
      unique case (wmerge[7:0])
        `FPDS_CMD_RELATIVE:
          start = 1'b1;
        `FPDS_CMD_COUNTER_REL:
        begin
          start      = 1'b1;
          start_dir  = target_q[31];
          start_move = FPDS_MOVE_COUNTER;
        end
        `FPDS_CMD_ABSOLUTE:
        begin
          start       = 1'b1;
          start_total = fpds_mag(abs_diff);
          start_dir   = !abs_diff[31];
          start_move  = FPDS_MOVE_ABSOLUTE;
        end
        default:
          start = 1'b0;
      endcase
    end
    // A zero-length move outputs nothing and never starts.
    if (start_total == 32'h0000_0000)
      start = 1'b0;
  end

  // --------------------------------------------------------------------
  // Deceleration point
  // --------------------------------------------------------------------
  assign remaining  = total_q - out_cnt_q;
  // Decel uses as many pulses as accel did, moved by the offset.
  assign auto_point = $signed({2'b00, acc_cnt_q})
                      + $signed({{2{offset_q[31]}}, offset_q});
  // Combinational, so in automatic mode a raised count lifts decel at once.
  assign decel_now  = manual_q ? (out_cnt_q >= dpoint_q)
                    : ($signed({2'b00, remaining}) <= auto_point);
  assign new_total  = fpds_mag(wmerge);

  assign drv.run        = (state_q == FPDS_RUN);
  assign drv.decel      = decel_now;
  assign drv.accel      = accel_q;
  assign drv.decel_rate = decel_q;
  assign drv.init_speed = init_q;
  assign drv.drive      = drive_q;

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  // Counts pulses, ends the move and applies count rewrites.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state_q   <= FPDS_IDLE;
      move_q    <= FPDS_MOVE_RELATIVE;
      total_q   <= 32'h0000_0000;
      out_cnt_q <= 32'h0000_0000;
      dir_q     <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        FPDS_IDLE:
          if (start)
          begin
            state_q   <= FPDS_RUN;
            move_q    <= start_move;
            total_q   <= start_total;
            out_cnt_q <= 32'h0000_0000;
            dir_q     <= start_dir;
          end
        FPDS_RUN:
        begin
          if (drv.step)
            out_cnt_q <= out_cnt_q + 32'h0000_0001;
          // Rewrites are ignored in absolute moves; the host keeps
          // direction, so only the magnitude is taken.
          if (tgt_wr && move_q != FPDS_MOVE_ABSOLUTE)
          begin
            total_q <= new_total;
            if (new_total <= out_cnt_q + {31'h0, drv.step})
              state_q <= FPDS_IDLE;
          end
          else if (drv.step && out_cnt_q + 32'h1 >= total_q)
            state_q <= FPDS_IDLE;
        end
      endcase
    end
  end

  // Pulses spent on acceleration, the budget for deceleration.
  always_ff @(posedge clock_i)
  begin
    if (rst_i || start)
      acc_cnt_q <= 32'h0000_0000;
    else if (drv.step && drv.run && !decel_now && !drv.at_top)
      acc_cnt_q <= acc_cnt_q + 32'h0000_0001;
  end

  // Logical position follows every pulse sent out.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      logpos_q <= 32'h0000_0000;
    else if (drv.step && drv.run)
      logpos_q <= dir_q ? logpos_q + 32'sd1 : logpos_q - 32'sd1;
  end

  // Drive pulse register toward the motor driver.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      pulse_q <= 1'b0;
    else
      pulse_q <= drv.step && drv.run;
  end

  // --------------------------------------------------------------------
  // Submodules and outputs
  // --------------------------------------------------------------------
  fpds_ramp #(.RAMP_DIV(RAMP_DIV)) u_ramp
  (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .drv     (drv)
  );

  fpds_pgen u_pgen
  (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .drv     (drv)
  );

  assign readdata_o    = rdata_q;
  assign waitrequest_o = waitreq_q;
  assign pulse_o       = pulse_q;
  assign dir_o         = dir_q;
  assign busy_o        = (state_q == FPDS_RUN);

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_rel_start: assert property (@(posedge clock_i) disable iff (rst_i)
    start && wmerge[7:0] == 8'h50 |=> busy_o && dir_o == !$past(target_q[31]))
    else $error("relative command did not start correctly");
  a_crel_dir: assert property (@(posedge clock_i) disable iff (rst_i)
    start && wmerge[7:0] == 8'h51 |=> dir_o == $past(target_q[31]))
    else $error("counter-relative direction wrong");
  a_abs_total: assert property (@(posedge clock_i) disable iff (rst_i)
    start && wmerge[7:0] == 8'h54 |=> total_q == $past(fpds_mag(abs_diff)))
    else $error("absolute pulse count wrong");
  a_end_count: assert property (@(posedge clock_i) disable iff (rst_i)
    busy_o && drv.step && out_cnt_q + 32'h1 == total_q && !tgt_wr
    |=> !busy_o)
    else $error("move did not end on last pulse");
  a_shrink_stop: assert property (@(posedge clock_i) disable iff (rst_i)
    busy_o && tgt_wr && move_q != FPDS_MOVE_ABSOLUTE
    && new_total <= out_cnt_q |=> !busy_o ##1 !pulse_o)
    else $error("shrunk count did not stop output");
  a_abs_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    busy_o && move_q == FPDS_MOVE_ABSOLUTE |=> total_q == $past(total_q))
    else $error("absolute count changed in flight");
  a_auto_decel: assert property (@(posedge clock_i) disable iff (rst_i)
    busy_o && !manual_q && $signed({2'b00, remaining}) <= auto_point
    |=> drv.speed <= $past(drv.speed))
    else $error("automatic decel point missed");
  a_offset_zero: assert property (@(posedge clock_i)
    $past(rst_i) |-> offset_q == 32'h0)
    else $error("offset not zero after reset");
  a_bus_answer: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(req) && waitreq_q |=> !waitrequest_o ##1 waitrequest_o)
    else $error("bus answer not one cycle");

endmodule : fpds_top
